/* design/ftr_pkg.sv */
/*
  Constants for the flash timing reload and auto-read register group:
  register indices, reset values, field positions and phase multipliers.
  Assumes a single core clock and a simple indexed register port.
*/
package ftr_pkg;
  localparam int IDX_W = 4;
  localparam logic [IDX_W-1:0] IDX_PRESCALE = 4'h0;
  localparam logic [IDX_W-1:0] IDX_PROG = 4'h1;
  localparam logic [IDX_W-1:0] IDX_MERASE = 4'h2;
  localparam logic [IDX_W-1:0] IDX_END = 4'h3;
  localparam logic [IDX_W-1:0] IDX_MEND = 4'h4;
  localparam logic [IDX_W-1:0] IDX_RCV = 4'h5;
  localparam logic [IDX_W-1:0] IDX_FUNC = 4'h6;
  localparam logic [IDX_W-1:0] IDX_FUNC_MIRROR = 4'h7;
  localparam logic [IDX_W-1:0] IDX_PROT = 4'h8;
  localparam logic [IDX_W-1:0] IDX_PROT_MIRROR = 4'h9;
  localparam logic [IDX_W-1:0] IDX_CSTART = 4'ha;
  localparam logic [IDX_W-1:0] IDX_CSTART_MIRROR = 4'hb;

  localparam logic [4:0] RST_PRESCALE = 5'h04;
  localparam logic [7:0] RST_PROG = 8'h16;
  localparam logic [7:0] RST_MERASE = 8'hea;
  localparam logic [7:0] RST_END = 8'h18;
  localparam logic [7:0] RST_MEND = 8'h3c;
  localparam logic [7:0] RST_RCV = 8'h04;

  localparam int CNT_W = 20;
  localparam logic [CNT_W-1:0] MUL_MERASE = 20'h01000;
  localparam logic [CNT_W-1:0] MUL_EIGHT = 20'h00008;
  localparam logic [CNT_W-1:0] MUL_ONE = 20'h00001;

  localparam int USB_EN_BIT = 0;
  localparam int BOOT_LSB = 0;
  localparam int BOOT_W = 4;
  localparam int CSTART_MID_LSB = 11;
  localparam int CSTART_LOW_W = 11;

  typedef enum logic [2:0] {
    FTR_IDLE = 3'h0,
    FTR_PULSE = 3'h1,
    FTR_MEND = 3'h3,
    FTR_ENDD = 3'h2,
    FTR_RCV = 3'h6
  } ftr_phase_e;
endpackage : ftr_pkg

/* design/ftr_flash_timing.sv */
/*
  Flash program/erase timing sequencer with its reload registers and the
  three reset-loaded auto-read registers.
  Assumes the register port, operation requests and USB status all come from
  logic on core_clk, and the information words are stable during reset.
*/
// What this block does
// - Module erase pulse lasts 4096 x (count+1) ticks
// - Module erase reload resets to EAh
// - End delay lasts (count+1) ticks
// - End delay reload resets to 18h
// - Module erase end delay 8 x (count+1) ticks
// - Module erase end reload resets to 3Ch
// - Recovery gap lasts (count+1) ticks
// - Recovery reload resets to 04h
// - Timing reloads are 8-bit read/write registers
// - Function word captured at reset, mirror identical
// - Transceiver enable clear forces low power
// - Protection word captured at reset, read-only
// - Code start displacement loaded in reset, read-only
// - Code start bits 14:11 are inverted boot field
// - Code start bits 10:0 read zero
// - Code start bit 15 reads zero
// - Prescaler divides clock by divisor+1
// - Program pulse lasts 8 x (count+1) ticks
`timescale 1ns/1ps
module ftr_flash_timing #(
  parameter int DATA_W = 16
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [ftr_pkg::IDX_W-1:0] reg_idx,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [DATA_W-1:0] info_function_word,
  input wire logic [DATA_W-1:0] info_protection_word,
  input wire logic start_program,
  input wire logic start_module_erase,
  input wire logic usb_ctrl_low_power,
  output logic flash_busy_flag,
  output logic program_pulse,
  output logic module_erase_pulse,
  output logic usb_xcvr_low_power,
  output logic [DATA_W-1:0] code_start_displacement
);
  typedef struct packed {
    ftr_pkg::ftr_phase_e phase;
    logic erase_op;
    logic [4:0] prescale_divisor;
    logic [4:0] pre_cnt;
    logic [7:0] program_pulse_count;
    logic [7:0] module_erase_count;
    logic [7:0] end_delay_count;
    logic [7:0] module_erase_end_count;
    logic [7:0] recovery_count;
    logic [ftr_pkg::CNT_W-1:0] phase_cnt;
    logic [DATA_W-1:0] function_word_copy;
    logic [DATA_W-1:0] protection_word_copy;
    logic [DATA_W-1:0] rdata;
  } ftr_state_s;

  ftr_state_s st;
  ftr_state_s next_st;
  logic tick;
  logic phase_done;
  logic busy;
  logic [DATA_W-1:0] cstart;

  // Phase length minus one, so terminal count is zero
  function automatic logic [ftr_pkg::CNT_W-1:0] ftr_len(
    input logic [ftr_pkg::CNT_W-1:0] mul,
    input logic [7:0] field
  );
    logic [ftr_pkg::CNT_W-1:0] prod;
    prod = ftr_pkg::CNT_W'(mul * ({12'h000, field} + 20'h00001));
    return prod - 20'h00001;
  endfunction : ftr_len

  assign busy = (st.phase != ftr_pkg::FTR_IDLE);
  // Compare with >= so lowering the divisor mid-count cannot skip a tick
  assign tick = (st.pre_cnt >= st.prescale_divisor);
  assign phase_done = tick && (st.phase_cnt == '0);

  always_comb begin
    cstart = '0;
    cstart[ftr_pkg::CSTART_MID_LSB +: ftr_pkg::BOOT_W] =
      ~st.protection_word_copy[ftr_pkg::BOOT_LSB +: ftr_pkg::BOOT_W];
  end

  always_comb begin
    next_st = st;
    next_st.pre_cnt = tick ? 5'h00 : st.pre_cnt + 5'h01;
    if (tick && busy) begin
      next_st.phase_cnt = st.phase_cnt - 20'h00001;
    end
    case (st.phase)
      ftr_pkg::FTR_IDLE: begin
        if (start_module_erase) begin
          next_st.phase = ftr_pkg::FTR_PULSE;
          next_st.erase_op = 1'b1;
          next_st.phase_cnt = ftr_len(ftr_pkg::MUL_MERASE, st.module_erase_count);
        end else if (start_program) begin
          next_st.phase = ftr_pkg::FTR_PULSE;
          next_st.erase_op = 1'b0;
          next_st.phase_cnt = ftr_len(ftr_pkg::MUL_EIGHT, st.program_pulse_count);
        end
      end
      ftr_pkg::FTR_PULSE: begin
        if (phase_done && st.erase_op) begin
          next_st.phase = ftr_pkg::FTR_MEND;
          next_st.phase_cnt = ftr_len(ftr_pkg::MUL_EIGHT, st.module_erase_end_count);
        end else if (phase_done) begin
          next_st.phase = ftr_pkg::FTR_ENDD;
          next_st.phase_cnt = ftr_len(ftr_pkg::MUL_ONE, st.end_delay_count);
        end
      end
      ftr_pkg::FTR_MEND: begin
        if (phase_done) begin
          next_st.phase = ftr_pkg::FTR_ENDD;
          next_st.phase_cnt = ftr_len(ftr_pkg::MUL_ONE, st.end_delay_count);
        end
      end
      ftr_pkg::FTR_ENDD: begin
        if (phase_done) begin
          next_st.phase = ftr_pkg::FTR_RCV;
          next_st.phase_cnt = ftr_len(ftr_pkg::MUL_ONE, st.recovery_count);
        end
      end
      ftr_pkg::FTR_RCV: begin
        if (phase_done) begin
          next_st.phase = ftr_pkg::FTR_IDLE;
        end
      end
      default: begin
        next_st.phase = ftr_pkg::FTR_IDLE;
      end
    endcase
    // Writes while busy are dropped so a running phase keeps its timing
    if (reg_wr && !busy) begin
      case (reg_idx)
        ftr_pkg::IDX_PRESCALE: next_st.prescale_divisor = reg_wdata[4:0];
        ftr_pkg::IDX_PROG: next_st.program_pulse_count = reg_wdata;
        ftr_pkg::IDX_MERASE: next_st.module_erase_count = reg_wdata;
        ftr_pkg::IDX_END: next_st.end_delay_count = reg_wdata;
        ftr_pkg::IDX_MEND: next_st.module_erase_end_count = reg_wdata;
        ftr_pkg::IDX_RCV: next_st.recovery_count = reg_wdata;
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_idx)
        ftr_pkg::IDX_PRESCALE: next_st.rdata = DATA_W'(st.prescale_divisor);
        ftr_pkg::IDX_PROG: next_st.rdata = DATA_W'(st.program_pulse_count);
        ftr_pkg::IDX_MERASE: next_st.rdata = DATA_W'(st.module_erase_count);
        ftr_pkg::IDX_END: next_st.rdata = DATA_W'(st.end_delay_count);
        ftr_pkg::IDX_MEND: next_st.rdata = DATA_W'(st.module_erase_end_count);
        ftr_pkg::IDX_RCV: next_st.rdata = DATA_W'(st.recovery_count);
        ftr_pkg::IDX_FUNC,
        ftr_pkg::IDX_FUNC_MIRROR: next_st.rdata = st.function_word_copy;
        ftr_pkg::IDX_PROT,
        ftr_pkg::IDX_PROT_MIRROR: next_st.rdata = st.protection_word_copy;
        ftr_pkg::IDX_CSTART,
        ftr_pkg::IDX_CSTART_MIRROR: next_st.rdata = cstart;
        default: next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st.phase <= ftr_pkg::FTR_IDLE;
      st.erase_op <= 1'b0;
      st.prescale_divisor <= ftr_pkg::RST_PRESCALE;
      st.pre_cnt <= 5'h00;
      st.program_pulse_count <= ftr_pkg::RST_PROG;
      st.module_erase_count <= ftr_pkg::RST_MERASE;
      st.end_delay_count <= ftr_pkg::RST_END;
      st.module_erase_end_count <= ftr_pkg::RST_MEND;
      st.recovery_count <= ftr_pkg::RST_RCV;
      st.phase_cnt <= '0;
      // Synchronous reset, so the info words are sampled while rstn is low
      st.function_word_copy <= info_function_word;
      st.protection_word_copy <= info_protection_word;
      st.rdata <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign flash_busy_flag = busy;
  assign program_pulse = (st.phase == ftr_pkg::FTR_PULSE) && !st.erase_op;
  assign module_erase_pulse = (st.phase == ftr_pkg::FTR_PULSE) && st.erase_op;
  assign usb_xcvr_low_power =
    !st.function_word_copy[ftr_pkg::USB_EN_BIT] || usb_ctrl_low_power;
  assign code_start_displacement = cstart;
endmodule : ftr_flash_timing

/* testbench/ftr_flash_timing_assertions.sv */
/* Assertion checker for the flash timing block, bound to its ports.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module ftr_flash_timing_chk #(
  parameter int DATA_W = 16
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [ftr_pkg::IDX_W-1:0] reg_idx,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [DATA_W-1:0] info_function_word,
  input wire logic [DATA_W-1:0] info_protection_word,
  input wire logic start_program,
  input wire logic start_module_erase,
  input wire logic usb_ctrl_low_power,
  input wire logic flash_busy_flag,
  input wire logic program_pulse,
  input wire logic module_erase_pulse,
  input wire logic usb_xcvr_low_power,
  input wire logic [DATA_W-1:0] code_start_displacement
);
  logic [DATA_W-1:0] fw_q;
  logic [DATA_W-1:0] pw_q;
  // Last words seen in reset, same edge the design captures
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fw_q <= info_function_word;
      pw_q <= info_protection_word;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_xcvr_power_follow: assert property (
    usb_xcvr_low_power == (!fw_q[0] | usb_ctrl_low_power)) else $error("xcvr power wrong");
  a_code_start_value: assert property (
    code_start_displacement == {1'b0, ~pw_q[3:0], 11'h000}) else $error("code start wrong");
  a_start_sets_busy: assert property (
    !flash_busy_flag && (start_program || start_module_erase) |=> flash_busy_flag)
    else $error("start not taken");
  a_erase_wins_start: assert property (
    !flash_busy_flag && start_module_erase |=> module_erase_pulse && !program_pulse)
    else $error("erase lost priority");
  a_prog_pulse_min: assert property (
    $rose(program_pulse) |-> program_pulse [*7]) else $error("program pulse short");
  a_prog_tail_busy: assert property (
    $fell(program_pulse) |-> flash_busy_flag [*2]) else $error("program tail short");
  a_erase_tail_busy: assert property (
    $fell(module_erase_pulse) |-> flash_busy_flag [*8]) else $error("erase tail short");
  a_rdata_holds: assert property (
    !$past(reg_rd) |-> $stable(reg_rdata)) else $error("read data moved");
  a_func_mirror_same: assert property (
    reg_rd && reg_idx == ftr_pkg::IDX_FUNC_MIRROR |=> reg_rdata == fw_q)
    else $error("mirror differs");
  cover property ($rose(program_pulse));
  cover property ($rose(module_erase_pulse));
  cover property (reg_rd && reg_idx == ftr_pkg::IDX_CSTART);
endmodule : ftr_flash_timing_chk
bind ftr_flash_timing ftr_flash_timing_chk #(.DATA_W(DATA_W)) u_chk (.core_clk, .rstn,
  .reg_idx, .reg_rd, .reg_rdata, .info_function_word, .info_protection_word, .start_program,
  .start_module_erase, .usb_ctrl_low_power, .flash_busy_flag, .program_pulse,
  .module_erase_pulse, .usb_xcvr_low_power, .code_start_displacement);

/* testbench/testbench.sv */
/* Self-checking bench for the flash timing block.
   Assumes the checker file is compiled alongside and binds itself. */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module testbench;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_idx = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [15:0] info_function_word = 16'h0000;
  logic [15:0] info_protection_word = 16'h0000;
  logic start_program = 1'b0;
  logic start_module_erase = 1'b0;
  logic usb_ctrl_low_power = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] code_start_displacement;
  logic flash_busy_flag, program_pulse, module_erase_pulse, usb_xcvr_low_power;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  always #4 core_clk = ~core_clk;
  ftr_flash_timing u_ftr_flash_timing (.core_clk, .rstn, .reg_idx, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .info_function_word, .info_protection_word, .start_program,
    .start_module_erase, .usb_ctrl_low_power, .flash_busy_flag, .program_pulse,
    .module_erase_pulse, .usb_xcvr_low_power, .code_start_displacement);
  task automatic test_done();
    $display("errors %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // Erase alone runs about 4100 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    step();
    reg_idx = i; reg_wdata = d; reg_wr = 1'b1;
    step();
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] i, input logic [15:0] e);
    step();
    reg_idx = i; reg_rd = 1'b1;
    step();
    reg_rd = 1'b0;
    `CHK(reg_rdata, e)
  endtask : rd
  task automatic t_reset(input logic [15:0] f, input logic [15:0] p);
    logic [15:0] cs;
    cs = {1'b0, ~p[3:0], 11'h000};
    rstn = 1'b0; info_function_word = f; info_protection_word = p;
    repeat (12) step();
    rstn = 1'b1;
    rd(4'h2, 16'h00ea);
    rd(4'h3, 16'h0018);
    rd(4'h4, 16'h003c);
    rd(4'h5, 16'h0004);
    rd(4'h6, f); rd(4'h7, f);
    rd(4'h8, p); rd(4'h9, p);
    rd(4'ha, cs); rd(4'hb, cs);
    `CHK(code_start_displacement, cs)
    usb_ctrl_low_power = 1'b0;
    step();
    `CHK(usb_xcvr_low_power, ~f[0])
    usb_ctrl_low_power = 1'b1;
    step();
    `CHK(usb_xcvr_low_power, 1'b1)
  endtask : t_reset
  task automatic t_rw();
    for (int i = 2; i < 6; i++) wr(4'(i), 8'ha0 + 8'(i));
    for (int i = 2; i < 6; i++) rd(4'(i), 16'h00a0 + 16'(i));
    wr(4'h6, 8'hff);
    rd(4'h6, info_function_word);
    rd(4'hf, 16'h0000);
  endtask : t_rw
  // Counts busy and pulse cycles; divisor 0 makes them exact
  task automatic t_seq(input logic er, input int pe, input int be);
    int np;
    int nb;
    np = 0; nb = 0;
    // Starts only from idle; no reload write while busy
    step();
    start_program = 1'b1; start_module_erase = er;
    step();
    start_program = 1'b0; start_module_erase = 1'b0;
    while (flash_busy_flag === 1'b1 && nb < 6000) begin
      nb++;
      if (program_pulse | module_erase_pulse) np++;
      step();
    end
    `CHK(np, pe)
    `CHK(nb, be)
  endtask : t_seq
  // Divisor 1: one tick per two clocks, first tick may come a clock early
  task automatic t_div();
    int np;
    int nb;
    np = 0; nb = 0;
    wr(4'h0, 8'h01); wr(4'h1, 8'h00); wr(4'h3, 8'h00); wr(4'h5, 8'h00);
    step();
    start_program = 1'b1;
    step();
    start_program = 1'b0;
    while (flash_busy_flag === 1'b1 && nb < 6000) begin
      nb++;
      if (program_pulse | module_erase_pulse) np++;
      step();
    end
    `CHK((np == 15) || (np == 16), 1'b1)
    `CHK(nb, np + 4)
  endtask : t_div
  initial begin
    t_reset(16'h1234, 16'h5a3c);
    t_rw();
    for (int i = 0; i < 6; i++) wr(4'(i), 8'h00);
    t_seq(1'b0, 8, 10);
    wr(4'h1, 8'h01); wr(4'h3, 8'h02); wr(4'h5, 8'h03);
    t_seq(1'b0, 16, 23);
    t_seq(1'b1, 4096, 4111);
    t_div();
    t_reset(16'h1235, 16'ha5c3);
    test_done();
  end
endmodule : testbench
